// >>> rtl/agth_top.sv
// Graphics-port target command handler: decode, queue and local completion.
`timescale 1ns/1ns
module agth_top
  import agth_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   link_clk_i,
  input  wire logic                   link_rst_n_i,
  input  wire logic                   req_valid_i,
  input  wire logic                   req_pci_i,
  input  wire logic [CMD_W-1:0]       req_cmd_i,
  input  wire logic [ADDR_W-1:0]      req_addr_i,
  input  wire logic [BE_W-1:0]        req_be_i,
  input  wire logic [1:0]             rate_sel_i,
  output logic                        req_ready_o,
  output logic                        retry_o,
  output logic                        rsp_valid_o,
  output logic [DATA_W-1:0]           rsp_data_o,
  output logic                        init_pipe_en_o,
  output logic                        init_sideband_en_o,
  output logic [1:0]                  rate_o,
  input  wire logic                   cpu_lock_here_i,
  input  wire logic                   cpu_lock_other_i,
  input  wire logic                   ext_card_present_i,
  input  wire logic [ADDR_W-1:0]      hub_base_i,
  output logic                        integrated_graphics_engine_en_o,
  output logic                        digital_video_out_port_en_o,
  output logic                        mem_valid_o,
  output logic [ADDR_W-1:0]           mem_addr_o,
  output logic [BE_W-1:0]             mem_be_o,
  output logic [2:0]                  mem_kind_o,
  output logic                        mem_snoop_o,
  input  wire logic                   mem_ready_i,
  output logic                        hub_valid_o,
  output logic [5:0]                  queue_count_o
);
  import agth_pkg::*;

  localparam int unsigned XW = ADDR_W + BE_W + CMD_W + 1;

  // ---------------- Link domain ----------------
  logic             lock_here_s1, lock_here_s2;
  logic             room_s1, room_s2;
  logic             cap_valid;
  logic [XW-1:0]    cap_word;
  logic             xfer_busy;
  logic             take;
  logic [XW-1:0]    xfer_word;
  logic             rsp_tog_s1, rsp_tog_s2, rsp_tog_s3;
  logic             queue_room;
  logic             rsp_toggle;

  always_ff @(posedge link_clk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      lock_here_s1  <= 1'b0;
      lock_here_s2  <= 1'b0;
      room_s1       <= 1'b0;
      room_s2       <= 1'b0;
    end else begin
      lock_here_s1  <= cpu_lock_here_i;
      lock_here_s2  <= lock_here_s1;
      room_s1       <= queue_room;
      room_s2       <= room_s1;
    end
  end

  // A PCI-style cycle under a lock held on this port is refused at once
  // rather than parked as a delayed read.
  assign retry_o     = req_valid_i & req_pci_i & lock_here_s2;
  // With a lock elsewhere the cycle is taken; the queue simply stops
  // draining snooped entries, so the ready drops once room runs out.
  assign req_ready_o = ~xfer_busy & room_s2 & ~retry_o;
  assign take        = req_valid_i & req_ready_o;
  assign xfer_word   = {req_pci_i, req_cmd_i, req_be_i, req_addr_i};

  agth_sync_hs #(
    .W (XW)
  ) u_req_cross (
    .src_clk_i   (link_clk_i),
    .src_rst_n_i (link_rst_n_i),
    .src_valid_i (take),
    .src_data_i  (xfer_word),
    .src_busy_o  (xfer_busy),
    .dst_clk_i   (mclk_i),
    .dst_rst_n_i (rst_n_i),
    .dst_valid_o (cap_valid),
    .dst_data_o  (cap_word)
  );

  always_ff @(posedge link_clk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      rsp_tog_s1 <= 1'b0;
      rsp_tog_s2 <= 1'b0;
      rsp_tog_s3 <= 1'b0;
    end else begin
      rsp_tog_s1 <= rsp_toggle;
      rsp_tog_s2 <= rsp_tog_s1;
      rsp_tog_s3 <= rsp_tog_s2;
    end
  end

  always_ff @(posedge link_clk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= '0;
    end else begin
      rsp_valid_o <= rsp_tog_s2 ^ rsp_tog_s3;
      rsp_data_o  <= FILL_DATA;
    end
  end

  // Transfer rate follows the configured selection; selection 3 is undefined and gives rate 2.
  always_ff @(posedge link_clk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      rate_o <= 2'h0;
    end else begin
      rate_o <= (rate_sel_i == 2'h3) ? 2'h2 : rate_sel_i;
    end
  end

  assign init_pipe_en_o     = 1'b0;
  assign init_sideband_en_o = 1'b0;

  // ---------------- Core domain ----------------
  logic              load_d;
  logic              c_pci;
  logic [CMD_W-1:0]  c_cmd;
  logic [BE_W-1:0]   c_be;
  logic [ADDR_W-1:0] c_addr;
  logic              c_hub;
  agth_rsp_t         c_rsp;
  agth_kind_t        c_kind;
  agth_state_t       state;
  logic [QPTR_W:0]   wr_ptr, rd_ptr;
  logic [5:0]        count;
  logic              q_wr;
  logic [ENT_W-1:0]  q_wdata;
  logic [ENT_W-1:0]  q_rdata;
  logic              q_empty;
  logic              q_full;
  logic              out_pend;
  logic              out_load;
  logic              lock_other_m1, lock_other_m2;
  logic              ext_s1, ext_s2;
  logic              snoop_ent;

  assign {c_pci, c_cmd, c_be, c_addr} = cap_word;
  assign c_hub = is_hub(c_addr, hub_base_i);

  always_comb begin
    c_rsp  = RSP_IGNORE;
    c_kind = KIND_RD_LO;
    if (c_pci) begin
      // PCI-style memory read/write commands; hub-bound ones are dropped.
      case (c_cmd)
        4'h6, 4'hc, 4'he: begin
          c_kind = KIND_RD_LO;
          c_rsp  = c_hub ? RSP_IGNORE : RSP_QUEUE;
        end
        4'h7, 4'hf: begin
          c_kind = KIND_WR_LO;
          c_rsp  = c_hub ? RSP_IGNORE : RSP_QUEUE;
        end
        default: c_rsp = RSP_IGNORE;
      endcase
    end else begin
      case (c_cmd)
        CMD_READ, CMD_LREAD: begin
          c_kind = KIND_RD_LO;
          c_rsp  = c_hub ? RSP_LOCAL : RSP_QUEUE;
        end
        CMD_READ_HP, CMD_LREAD_HP: begin
          c_kind = KIND_RD_HI;
          c_rsp  = c_hub ? RSP_LOCAL : RSP_QUEUE;
        end
        CMD_WRITE: begin
          c_kind = KIND_WR_LO;
          c_rsp  = c_hub ? RSP_DROPWR : RSP_QUEUE;
        end
        CMD_WRITE_HP: begin
          c_kind = KIND_WR_HI;
          c_rsp  = c_hub ? RSP_DROPWR : RSP_QUEUE;
        end
        CMD_FLUSH: c_rsp = RSP_LOCAL;
        CMD_FENCE: begin
          c_kind = KIND_FENCE;
          c_rsp  = RSP_FENCE;
        end
        default: c_rsp = RSP_IGNORE;
      endcase
    end
  end

  // Hub-bound graphics-port writes keep their slot but lose every byte enable.
  always_comb begin
    q_wr    = 1'b0;
    q_wdata = '0;
    if (state == ST_CAPTURE && !q_full) begin
      q_wdata[ENT_ADDR_LSB +: ADDR_W] = c_addr;
      q_wdata[ENT_BE_LSB +: BE_W]     =
        (c_rsp == RSP_DROPWR) ? BE_NONE : c_be;
      q_wdata[ENT_KIND_LSB +: 3]      = c_kind;
      q_wr = (c_rsp == RSP_QUEUE) || (c_rsp == RSP_DROPWR) ||
             (c_rsp == RSP_FENCE);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE:    if (cap_valid) state <= ST_CAPTURE;
        ST_CAPTURE: if (!q_full) state <= ST_ISSUE;
        ST_ISSUE:   state <= ST_REPLY;
        ST_REPLY:   state <= ST_IDLE;
        default:    state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_toggle <= 1'b0;
    end else if (state == ST_CAPTURE && !q_full && c_rsp == RSP_LOCAL) begin
      rsp_toggle <= ~rsp_toggle;
    end
  end

  // Snoop marker per slot: PCI-style entries snoop, graphics ones never.
  logic [QDEPTH-1:0] snoop_tag;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      snoop_tag <= '0;
    end else if (q_wr) begin
      snoop_tag[wr_ptr[QPTR_W-1:0]] <= c_pci;
    end
  end

  agth_req_mem u_queue (
    .mclk_i    (mclk_i),
    .wr_en_i   (q_wr),
    .wr_addr_i (wr_ptr[QPTR_W-1:0]),
    .wr_data_i (q_wdata),
    .rd_addr_i (rd_ptr[QPTR_W-1:0]),
    .rd_data_o (q_rdata)
  );

  assign q_empty = (wr_ptr == rd_ptr);
  assign q_full  = (wr_ptr[QPTR_W-1:0] == rd_ptr[QPTR_W-1:0]) &&
                   (wr_ptr[QPTR_W] != rd_ptr[QPTR_W]);
  assign count   = 6'(wr_ptr - rd_ptr);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_other_m1 <= 1'b0;
      lock_other_m2 <= 1'b0;
      ext_s1        <= 1'b0;
      ext_s2        <= 1'b0;
    end else begin
      lock_other_m1 <= cpu_lock_other_i;
      lock_other_m2 <= lock_other_m1;
      ext_s1        <= ext_card_present_i;
      ext_s2        <= ext_s1;
    end
  end

  // A snooping entry cannot leave while a processor lock blocks snoops.
  assign snoop_ent = snoop_tag[rd_ptr[QPTR_W-1:0]];
  // Only one entry is in flight towards the memory port; this costs a
  // bubble per request but a held request can never be overwritten.
  assign out_load  = !q_empty && !out_pend && !load_d && !(
                     snoop_ent && lock_other_m2);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (q_wr) wr_ptr <= wr_ptr + 1'b1;
      if (out_load) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Read data lag one cycle, so the fetched slot is captured as it lands.
  logic snoop_d;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_d  <= 1'b0;
      snoop_d <= 1'b0;
    end else begin
      load_d  <= out_load;
      snoop_d <= snoop_ent;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_pend    <= 1'b0;
      mem_addr_o  <= '0;
      mem_be_o    <= '0;
      mem_kind_o  <= 3'h0;
      mem_snoop_o <= 1'b0;
    end else if (load_d) begin
      out_pend    <= 1'b1;
      mem_addr_o  <= q_rdata[ENT_ADDR_LSB +: ADDR_W];
      mem_be_o    <= q_rdata[ENT_BE_LSB +: BE_W];
      mem_kind_o  <= q_rdata[ENT_KIND_LSB +: 3];
      mem_snoop_o <= snoop_d;
    end else if (mem_ready_i) begin
      out_pend <= 1'b0;
    end
  end

  assign mem_valid_o   = out_pend;
  assign hub_valid_o   = 1'b0;
  assign queue_room    = (count < 6'(QDEPTH - 1));
  assign queue_count_o = count;

  assign integrated_graphics_engine_en_o = ~ext_s2;
  assign digital_video_out_port_en_o     = ~ext_s2;

endmodule : agth_top

// >>> rtl/agth_pkg.sv
// Shared constants and types for the graphics-port target command handler.
package agth_pkg;

  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned DATA_W      = 64;
  localparam int unsigned BE_W        = 8;
  localparam int unsigned QDEPTH      = 32;
  localparam int unsigned QPTR_W      = 5;
  localparam int unsigned CMD_W       = 4;

  // Queue entry field layout.
  localparam int unsigned ENT_ADDR_LSB = 0;
  localparam int unsigned ENT_BE_LSB   = 32;
  localparam int unsigned ENT_KIND_LSB = 40;
  localparam int unsigned ENT_W        = 43;

  // Command encodings seen on the link.
  localparam logic [3:0] CMD_READ      = 4'h0;
  localparam logic [3:0] CMD_READ_HP   = 4'h1;
  localparam logic [3:0] CMD_WRITE     = 4'h4;
  localparam logic [3:0] CMD_WRITE_HP  = 4'h5;
  localparam logic [3:0] CMD_LREAD     = 4'h8;
  localparam logic [3:0] CMD_LREAD_HP  = 4'h9;
  localparam logic [3:0] CMD_FLUSH     = 4'ha;
  localparam logic [3:0] CMD_FENCE     = 4'hc;

  // Queue entry kinds.
  typedef enum logic [2:0] {
    KIND_RD_LO  = 3'h0,
    KIND_RD_HI  = 3'h1,
    KIND_WR_LO  = 3'h2,
    KIND_WR_HI  = 3'h3,
    KIND_FENCE  = 3'h4
  } agth_kind_t;

  // Response classes chosen by the core-side decoder.
  typedef enum logic [2:0] {
    RSP_IGNORE  = 3'h0,
    RSP_QUEUE   = 3'h1,
    RSP_LOCAL   = 3'h2,
    RSP_DROPWR  = 3'h3,
    RSP_FENCE   = 3'h4
  } agth_rsp_t;

  // Handler state machine, Gray along idle-capture-issue-reply.
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_ISSUE   = 2'b11,
    ST_REPLY   = 2'b10
  } agth_state_t;

  localparam logic [ADDR_W-1:0] HUB_BASE_RST = 32'h8000_0000;
  localparam logic [DATA_W-1:0] FILL_DATA    = 64'hdead_beef_dead_beef;
  localparam logic [BE_W-1:0]   BE_NONE      = 8'h00;

  // True when the address falls in the hub window instead of main memory.
  function automatic logic is_hub(input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] base);
    return addr >= base;
  endfunction : is_hub

endpackage : agth_pkg

// >>> rtl/agth_req_mem.sv
// Request queue storage with registered read data.
`timescale 1ns/1ns
module agth_req_mem
  import agth_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 wr_en_i,
  input  wire logic [QPTR_W-1:0]    wr_addr_i,
  input  wire logic [ENT_W-1:0]     wr_data_i,
  input  wire logic [QPTR_W-1:0]    rd_addr_i,
  output logic      [ENT_W-1:0]     rd_data_o
);
  import agth_pkg::*;

  logic [ENT_W-1:0] mem [QDEPTH];

  always_ff @(posedge mclk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    rd_data_o <= mem[rd_addr_i];
  end

endmodule : agth_req_mem

// >>> rtl/agth_sync_hs.sv
// Four-phase handshake crossing a word from one clock domain to another.
`timescale 1ns/1ns
module agth_sync_hs
  import agth_pkg::*;
#(
  parameter int unsigned W = 8
)(
  input  wire logic          src_clk_i,
  input  wire logic          src_rst_n_i,
  input  wire logic          src_valid_i,
  input  wire logic [W-1:0]  src_data_i,
  output logic               src_busy_o,
  input  wire logic          dst_clk_i,
  input  wire logic          dst_rst_n_i,
  output logic               dst_valid_o,
  output logic [W-1:0]       dst_data_o
);
  import agth_pkg::*;

  logic         req;
  logic [W-1:0] hold;
  logic         ack_s1;
  logic         ack_s2;
  logic         req_s1;
  logic         req_s2;
  logic         req_s3;

  // The word stays frozen while the request is up so the far side sees
  // stable data once the synchronised request arrives.
  always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
    if (!src_rst_n_i) begin
      req  <= 1'b0;
      hold <= '0;
    end else if (!req && !ack_s2 && src_valid_i) begin
      req  <= 1'b1;
      hold <= src_data_i;
    end else if (req && ack_s2) begin
      req <= 1'b0;
    end
  end

  always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
    if (!src_rst_n_i) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= req_s2;
      ack_s2 <= ack_s1;
    end
  end

  assign src_busy_o = req | ack_s2;

  always_ff @(posedge dst_clk_i or negedge dst_rst_n_i) begin
    if (!dst_rst_n_i) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= req;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  always_ff @(posedge dst_clk_i or negedge dst_rst_n_i) begin
    if (!dst_rst_n_i) begin
      dst_valid_o <= 1'b0;
      dst_data_o  <= '0;
    end else begin
      dst_valid_o <= req_s2 & ~req_s3;
      if (req_s2 & ~req_s3) begin
        dst_data_o <= hold;
      end
    end
  end

endmodule : agth_sync_hs

// >>> testbench/agth_properties.sv
// Port-level checker for the graphics-port target command handler.
`timescale 1ns/1ns
module agth_properties
  import agth_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              rst_n_i,
  input wire logic              link_clk_i,
  input wire logic              link_rst_n_i,
  input wire logic              req_valid_i,
  input wire logic              req_pci_i,
  input wire logic              req_ready_o,
  input wire logic              retry_o,
  input wire logic              rsp_valid_o,
  input wire logic              init_pipe_en_o,
  input wire logic              init_sideband_en_o,
  input wire logic [1:0]        rate_o,
  input wire logic              ext_card_present_i,
  input wire logic [ADDR_W-1:0] hub_base_i,
  input wire logic              integrated_graphics_engine_en_o,
  input wire logic              digital_video_out_port_en_o,
  input wire logic              mem_valid_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [BE_W-1:0]   mem_be_o,
  input wire logic [2:0]        mem_kind_o,
  input wire logic              mem_ready_i,
  input wire logic              hub_valid_o,
  input wire logic [5:0]        queue_count_o
);
  a_no_enh_init: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !init_pipe_en_o && !init_sideband_en_o)
    else $error("initiator protocol enabled");
  a_no_hub_fwd: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i) !hub_valid_o)
    else $error("request forwarded to hub");
  a_engine_off: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i) ext_card_present_i [*4]
    |-> !integrated_graphics_engine_en_o && !digital_video_out_port_en_o)
    else $error("engine or video left on with card");
  a_engine_on: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i) !ext_card_present_i [*4]
    |-> integrated_graphics_engine_en_o && digital_video_out_port_en_o)
    else $error("engine or video off without card");
  a_mem_hold: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i) mem_valid_o && !mem_ready_i
    |=> mem_valid_o && $stable(mem_addr_o) && $stable(mem_kind_o)
    && $stable(mem_be_o)) else $error("memory request changed while held");
  a_kind_legal: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    mem_valid_o |-> mem_kind_o <= 3'h4) else $error("bad entry kind");
  a_hub_write: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i) mem_valid_o
    && mem_addr_o >= hub_base_i && mem_kind_o != KIND_FENCE
    |-> mem_kind_o inside {KIND_WR_LO, KIND_WR_HI} && mem_be_o == BE_NONE)
    else $error("hub-bound request reached memory wrongly");
  a_queue_bound: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i) queue_count_o <= 6'h20)
    else $error("queue count above depth");
  a_retry_cause: assert property (
    @(posedge link_clk_i) disable iff (!link_rst_n_i)
    retry_o |-> req_valid_i && req_pci_i && !req_ready_o)
    else $error("retry without locked frame cycle");
  a_rsp_pulse: assert property (
    @(posedge link_clk_i) disable iff (!link_rst_n_i)
    rsp_valid_o |=> !rsp_valid_o) else $error("response longer than one");
  a_rate_legal: assert property (
    @(posedge link_clk_i) disable iff (!link_rst_n_i) rate_o != 2'h3)
    else $error("undefined rate");
endmodule : agth_properties

bind agth_top agth_properties i_agth_properties (.*);

// >>> testbench/agth_master.sv
// Behavioural graphics-port master issuing one request per handshake.
`timescale 1ns/1ns
module agth_master
  import agth_pkg::*;
(
  input  wire logic          link_clk_i,
  input  wire logic          req_ready_i,
  input  wire logic          retry_i,
  output logic               req_valid_o,
  output logic               req_pci_o,
  output logic [CMD_W-1:0]   req_cmd_o,
  output logic [ADDR_W-1:0]  req_addr_o,
  output logic [BE_W-1:0]    req_be_o
);
  initial begin
    req_valid_o = 1'b0;
    req_pci_o = 1'b0;
    req_cmd_o = 4'hf;
    req_addr_o = 32'h0;
    req_be_o = 8'h0;
  end
  // Result 0 taken, 1 retried, 2 withdrawn after max_wait edges.
  task automatic send(input logic pci, input logic [CMD_W-1:0] cmd,
      input logic [ADDR_W-1:0] addr, input logic [BE_W-1:0] be,
      input int max_wait, output int res);
    res = 2;
    @(posedge link_clk_i);
    #2 req_pci_o = pci;
    req_cmd_o = cmd;
    req_addr_o = addr;
    req_be_o = be;
    req_valid_o = 1'b1;
    for (int n = 0; n < max_wait && res == 2; n++) begin
      @(posedge link_clk_i);
      if (req_ready_i === 1'b1) res = 0;
      else if (retry_i === 1'b1) res = 1;
    end
    // A released bus shows the inverse so stale values cannot pass.
    #2 req_valid_o = 1'b0;
    req_pci_o = ~pci;
    req_cmd_o = ~cmd;
    req_addr_o = ~addr;
    req_be_o = ~be;
  endtask : send
endmodule : agth_master

// >>> testbench/test_agp_target_command_handler.sv
// Self-checking bench for the graphics-port target command handler.
`timescale 1ns/1ns
module test_agp_target_command_handler;
  import agth_pkg::*;
  localparam logic [31:0] LO = 32'h0000_1000;
  localparam logic [31:0] HI = 32'h9000_0040;
  logic              mclk_i = 1'b0, link_clk_i = 1'b0;
  logic              rst_n_i, link_rst_n_i, req_valid_i, req_pci_i;
  logic [CMD_W-1:0]  req_cmd_i;
  logic [ADDR_W-1:0] req_addr_i, mem_addr_o, hub_base_i;
  logic [BE_W-1:0]   req_be_i, mem_be_o;
  logic [1:0]        rate_sel_i, rate_o;
  logic              req_ready_o, retry_o, rsp_valid_o, init_pipe_en_o;
  logic              init_sideband_en_o, cpu_lock_here_i, cpu_lock_other_i;
  logic              ext_card_present_i, integrated_graphics_engine_en_o;
  logic              digital_video_out_port_en_o, mem_valid_o, mem_snoop_o;
  logic              mem_ready_i, hub_valid_o;
  logic [DATA_W-1:0] rsp_data_o;
  logic [2:0]        mem_kind_o;
  logic [5:0]        queue_count_o;
  int                error_cnt = 0, n_checks = 0, rsp_cnt = 0, res;

  agth_top i_agth_top (.*);
  agth_master i_agth_master (.link_clk_i(link_clk_i),
    .req_ready_i(req_ready_o), .retry_i(retry_o),
    .req_valid_o(req_valid_i), .req_pci_o(req_pci_i),
    .req_cmd_o(req_cmd_i), .req_addr_o(req_addr_i), .req_be_o(req_be_i));

  always #20 mclk_i = ~mclk_i;
  always begin
    #63 link_clk_i = 1'b1;
    #62 link_clk_i = 1'b0;
  end
  always @(posedge link_clk_i) if (rsp_valid_o === 1'b1) rsp_cnt++;

  task automatic end_sim();
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [63:0] e, g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic get_mem(output logic g, output logic [2:0] k,
      output logic [31:0] a, output logic [7:0] b, output logic s);
    g = 1'b0;
    for (int n = 0; n < 200 && !g; n++) begin
      @(posedge mclk_i);
      g = (mem_valid_o === 1'b1);
      {k, a, b, s} = {mem_kind_o, mem_addr_o, mem_be_o, mem_snoop_o};
    end
    #2 mem_ready_i = g;
    @(posedge mclk_i);
    #2 mem_ready_i = 1'b0;
  endtask : get_mem

  task automatic mem_req(input logic p, input logic [3:0] c,
      input logic [31:0] ad, input logic [2:0] kd, input logic sn);
    logic g, s;
    logic [2:0] k;
    logic [31:0] a;
    logic [7:0] b;
    i_agth_master.send(p, c, ad, 8'h5a, 64, res);
    chk("taken", 0, res);
    get_mem(g, k, a, b, s);
    chk("mem_valid", 1, g);
    if (kd != 3'h7) chk("kind", kd, k);
    if (kd != KIND_FENCE) chk("addr", ad, a);
    if (kd inside {KIND_WR_LO, KIND_WR_HI})
      chk("be", ad >= HI ? BE_NONE : 8'h5a, b);
    chk("snoop", sn, s);
  endtask : mem_req

  task automatic no_rsp(input logic p, input logic [3:0] c,
      input logic [31:0] ad);
    int n;
    n = rsp_cnt;
    i_agth_master.send(p, c, ad, 8'hff, 64, res);
    repeat (40) @(posedge mclk_i);
    chk("mem_valid", 0, mem_valid_o);
    chk("rsp", n, rsp_cnt);
  endtask : no_rsp

  task automatic local_rsp(input logic [3:0] c, input logic [31:0] ad);
    int m;
    m = rsp_cnt;
    i_agth_master.send(1'b0, c, ad, 8'hff, 64, res);
    for (int n = 0; n < 60 && rsp_cnt == m; n++) @(posedge link_clk_i);
    chk("rsp", m + 1, rsp_cnt);
    chk("rsp_data", FILL_DATA, rsp_data_o);
    repeat (20) @(posedge mclk_i);
    chk("mem_valid", 0, mem_valid_o);
  endtask : local_rsp

  task automatic t_misc();
    for (int r = 0; r < 4; r++) begin
      @(posedge mclk_i);
      #2 rate_sel_i = r[1:0];
      repeat (12) @(posedge mclk_i);
      chk("rate", r == 3 ? 2 : r, rate_o);
    end
    #2 ext_card_present_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    chk("engine", 2'b00, {integrated_graphics_engine_en_o,
        digital_video_out_port_en_o});
    #2 ext_card_present_i = 1'b0;
    repeat (8) @(posedge mclk_i);
    chk("engine", 2'b11, {integrated_graphics_engine_en_o,
        digital_video_out_port_en_o});
  endtask : t_misc

  task automatic t_agp();
    logic [3:0] c [6] = '{CMD_READ, CMD_READ_HP, CMD_LREAD, CMD_LREAD_HP,
                          CMD_WRITE, CMD_WRITE_HP};
    logic [2:0] k [6] = '{KIND_RD_LO, KIND_RD_HI, KIND_RD_LO, KIND_RD_HI,
                          KIND_WR_LO, KIND_WR_HI};
    for (int i = 0; i < 6; i++) mem_req(1'b0, c[i], LO + i * 8, k[i], 1'b0);
    mem_req(1'b0, CMD_WRITE, HI, KIND_WR_LO, 1'b0);
    mem_req(1'b0, CMD_WRITE_HP, HI, KIND_WR_HI, 1'b0);
    for (int i = 0; i < 4; i++) local_rsp(c[i], HI);
  endtask : t_agp

  task automatic t_local();
    logic [3:0] r [8] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hb, 4'hd, 4'he, 4'hf};
    int n;
    local_rsp(CMD_FLUSH, LO);
    n = rsp_cnt;
    mem_req(1'b0, CMD_FENCE, LO, KIND_FENCE, 1'b0);
    chk("rsp", n, rsp_cnt);
    for (int i = 0; i < 8; i++) no_rsp(1'b0, r[i], LO);
  endtask : t_local

  task automatic t_pci();
    logic g, s;
    logic [2:0] k;
    logic [31:0] a;
    logic [7:0] b;
    mem_req(1'b1, 4'h7, LO, KIND_WR_LO, 1'b1);
    mem_req(1'b0, CMD_READ, LO, KIND_RD_LO, 1'b0);
    mem_req(1'b1, 4'he, LO, KIND_RD_LO, 1'b1);
    no_rsp(1'b1, 4'h6, HI);
    no_rsp(1'b1, 4'h2, LO);
    #2 cpu_lock_other_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    i_agth_master.send(1'b1, 4'hc, LO, 8'hff, 64, res);
    chk("taken", 0, res);
    repeat (40) @(posedge mclk_i);
    chk("mem_valid", 0, mem_valid_o);
    #2 cpu_lock_other_i = 1'b0;
    get_mem(g, k, a, b, s);
    chk("snoop", 2'b11, {g, s});
    cpu_lock_here_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    i_agth_master.send(1'b1, 4'h6, LO, 8'hff, 64, res);
    chk("retried", 1, res);
    mem_req(1'b0, CMD_READ_HP, LO, KIND_RD_HI, 1'b0);
    cpu_lock_here_i = 1'b0;
  endtask : t_pci

  task automatic t_fill();
    logic g, s;
    logic [2:0] k;
    logic [31:0] a;
    logic [7:0] b;
    int tk;
    tk = 0;
    res = 0;
    for (int n = 0; n < 40 && res == 0; n++) begin
      i_agth_master.send(1'b0, CMD_READ, LO, 8'hff, 40, res);
      if (res == 0) tk++;
    end
    repeat (20) @(posedge mclk_i);
    chk("taken", QDEPTH, tk);
    chk("queue_count", QDEPTH - 1, queue_count_o);
    for (int n = 0; n < tk; n++) get_mem(g, k, a, b, s);
    repeat (4) @(posedge mclk_i);
    chk("queue_count", 0, queue_count_o);
  endtask : t_fill

  initial begin
    {rst_n_i, link_rst_n_i, mem_ready_i, rate_sel_i} = '0;
    {cpu_lock_here_i, cpu_lock_other_i, ext_card_present_i} = '0;
    hub_base_i = HUB_BASE_RST;
    repeat (4) @(posedge mclk_i);
    #2 rst_n_i = 1'b1;
    repeat (3) @(posedge link_clk_i);
    #2 link_rst_n_i = 1'b1;
    repeat (4) @(posedge link_clk_i);
    t_misc();
    t_agp();
    t_local();
    t_pci();
    t_fill();
    end_sim();
  end

  initial begin
    #1_000_000;
    error_cnt++;
    end_sim();
  end
endmodule : test_agp_target_command_handler
